// ==== include/dual_adc_consts.svh ====
// constants of the dual converter output control: offsets, fields, resets
// assumes a 32-bit AXI4-Lite register port and a 25 MHz ref_clk
//
// Behaviour
// R1: each channel samples on its own clock's rising edge, independently.
// R2: swap select high routes channel A to bus A, channel B to bus B.
// R3: swap select low crosses them: channel A on bus B, B on A.
// R4: one-bus interleave ties swap select and both sample clocks to one clock.
// R5: interleaved single-bus use is advised against above 80Msps.
// R6: shutdown low, enable low: convert and drive bus and range flag.
// R7: shutdown low, enable high: keep converting, outputs high impedance.
// R8: shutdown high, enable low: nap mode, outputs high impedance.
// R9: shutdown high, enable high: sleep mode, outputs high impedance.
// R10: one shared mode setting governs both channels.
// R11: mode ground/one third: offset binary, stabilizer off/on.
// R12: mode two thirds: two's complement, stabilizer on; full: stabilizer off.
// R13: range flag high when the result over- or underflowed, else low.
// R14: each bus carries ten result bits, highest bit most significant.
// R15: a sample appears on the bus five sample clocks after it was taken.
// R16: two's complement is offset binary, MSB inverted; flag aligned to word.
// R17: interleaved, each half clock period shows the channel routed there.
`ifndef DUAL_ADC_CONSTS_SVH
`define DUAL_ADC_CONSTS_SVH

`define RES_W 10
`define PIPE_LAT 5
`define SYNC_LEN 3
`define AXI_AW 4

`define ADDR_CTRL 4'h0
`define ADDR_STAT 4'h4
`define ADDR_RES_A 4'h8
`define ADDR_RES_B 4'hC

// ctrl: swap, follow, pd_a, oen_a, pd_b, oen_b, mode[7:6]
`define CTRL_W 8
`define CTRL_RST 8'h01

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== include/dual_adc_pkg.sv ====
// types of the dual converter output control
// assumes dual_adc_consts.svh is on the include path
`include "dual_adc_consts.svh"

package dual_adc_pkg;

   typedef enum logic [3:0] {
      CH_NORMAL = 4'b0001,
      CH_HIZ = 4'b0010,
      CH_NAP = 4'b0100,
      CH_SLEEP = 4'b1000
   } chan_state_t;

   typedef enum logic [1:0] {
      MODE_GND = 2'b00,
      MODE_THIRD = 2'b01,
      MODE_TWO_THIRDS = 2'b10,
      MODE_FULL = 2'b11
   } mode_level_t;

   typedef struct packed {
      mode_level_t mode;
      logic oen_b;
      logic pd_b;
      logic oen_a;
      logic pd_a;
      logic swap_follow;
      logic swap_sel;
   } ctrl_t;

   typedef struct packed {
      logic range;
      logic [`RES_W-1:0] code;
   } sample_t;

endpackage

// ==== design/dual_adc_output_control.sv ====
// output control of a dual ten-bit converter, with AXI4-Lite control port
// assumes raw codes arrive on ref_clk; sample clocks are asynchronous pins
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dual_adc_consts.svh"

module dual_adc_output_control
   import dual_adc_pkg::*;
#(
   parameter int LAT = `PIPE_LAT
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // sample clock pins
   input wire logic sample_clock_chan_a,
   input wire logic sample_clock_chan_b,
   // raw conversion from the core, offset binary
   input wire logic [`RES_W-1:0] raw_code_chan_a,
   input wire logic raw_range_chan_a,
   input wire logic [`RES_W-1:0] raw_code_chan_b,
   input wire logic raw_range_chan_b,
   // output buses
   output logic [`RES_W-1:0] result_bus_a,
   output logic result_bus_a_oe,
   output logic range_flag_bus_a,
   output logic range_flag_bus_a_oe,
   output logic [`RES_W-1:0] result_bus_b,
   output logic result_bus_b_oe,
   output logic range_flag_bus_b,
   output logic range_flag_bus_b_oe,
   output logic duty_stab_on,
   // axi4-lite slave
   input wire logic [`AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   if (LAT < 1 || LAT > 16) begin : g_lat_check
      $error("LAT out of range");
   end

   function automatic chan_state_t mode_of(input logic pd, input logic oen);
      case ({pd, oen})
         2'b00: mode_of = CH_NORMAL;
         2'b01: mode_of = CH_HIZ;
         2'b10: mode_of = CH_NAP;
         default: mode_of = CH_SLEEP;
      endcase
   endfunction

   function automatic sample_t format(input sample_t s, input logic twos);
      format = s;
      format.code[`RES_W-1] = s.code[`RES_W-1] ^ twos; // [R16]
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // sample clock synchronisers and edge detect

   logic [`SYNC_LEN-1:0] sync_q [2];
   logic [`SYNC_LEN-1:0] sync_d [2];
   logic [1:0] edge_s;
   logic [1:0] clk_pin;
   logic [1:0] lvl_q, lvl_d;

   assign clk_pin = {sample_clock_chan_b, sample_clock_chan_a};

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         sync_d[c] = {sync_q[c][`SYNC_LEN-2:0], clk_pin[c]};
         // a level counts once stages two and three agree, so a
         // metastable first stage cannot make a false edge
         lvl_d[c] = (sync_q[c][1] == sync_q[c][2]) ? sync_q[c][2] : lvl_q[c];
         edge_s[c] = sync_q[c][1] & sync_q[c][2] & ~lvl_q[c]; // [R1]
      end
   end

   always_ff @(posedge ref_clk) begin
      for (int c = 0; c < 2; c++) begin
         if (sys_rst) begin
            sync_q[c] <= '0;
            lvl_q[c] <= 1'b0;
         end else begin
            sync_q[c] <= sync_d[c];
            lvl_q[c] <= lvl_d[c];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control register and channel states

   ctrl_t ctrl_q, ctrl_d;
   chan_state_t state_q [2];
   chan_state_t state_d [2];
   logic twos_q, twos_d;
   logic stab_q, stab_d;
   logic swap_q, swap_d;
   logic wr_ctrl;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl && wstrb_q[0]) begin
         ctrl_d = ctrl_t'(wdata_q[`CTRL_W-1:0]);
      end
      state_d[0] = mode_of(ctrl_q.pd_a, ctrl_q.oen_a); // [R6] [R7] [R8] [R9]
      state_d[1] = mode_of(ctrl_q.pd_b, ctrl_q.oen_b);
      // one setting for both channels [R10]
      twos_d = ctrl_q.mode[1]; // [R11] [R12]
      stab_d = (ctrl_q.mode == MODE_THIRD) ||
               (ctrl_q.mode == MODE_TWO_THIRDS); // [R11] [R12]
      // follow mode ties the swap to channel A's clock level [R4] [R17]
      swap_d = ctrl_q.swap_follow ? lvl_q[0] : ctrl_q.swap_sel;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ctrl_q <= ctrl_t'(`CTRL_RST);
         state_q[0] <= CH_NORMAL;
         state_q[1] <= CH_NORMAL;
         twos_q <= 1'b0;
         stab_q <= 1'b0;
         swap_q <= 1'b1;
      end else begin
         ctrl_q <= ctrl_d;
         state_q[0] <= state_d[0];
         state_q[1] <= state_d[1];
         twos_q <= twos_d;
         stab_q <= stab_d;
         swap_q <= swap_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // conversion pipelines, halted in nap and sleep

   sample_t pipe_q [2][LAT];
   sample_t pipe_d [2][LAT];
   sample_t word_q [2];
   sample_t word_d [2];
   sample_t raw [2];
   logic [1:0] active;

   assign raw[0] = '{range: raw_range_chan_a, code: raw_code_chan_a};
   assign raw[1] = '{range: raw_range_chan_b, code: raw_code_chan_b};

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         active[c] = (state_q[c] == CH_NORMAL) || (state_q[c] == CH_HIZ);
         pipe_d[c] = pipe_q[c];
         word_d[c] = word_q[c];
         if (edge_s[c] && active[c]) begin // [R1] [R7]
            pipe_d[c][0] = raw[c]; // [R13]
            for (int i = 1; i < LAT; i++) begin
               pipe_d[c][i] = pipe_q[c][i-1];
            end
            // flag travels with its word [R15] [R16]
            word_d[c] = format(pipe_q[c][LAT-1], twos_q);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      for (int c = 0; c < 2; c++) begin
         if (sys_rst) begin
            for (int i = 0; i < LAT; i++) begin
               pipe_q[c][i] <= '0;
            end
            word_q[c] <= '0;
         end else begin
            pipe_q[c] <= pipe_d[c];
            word_q[c] <= word_d[c];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output bus routing, registered so every pin comes from a flop

   sample_t bus_q [2];
   sample_t bus_d [2];
   logic [1:0] bus_oe_q, bus_oe_d;

   always_comb begin
      // bus index 0 is bus A [R2] [R3] [R14]
      bus_d[0] = swap_q ? word_q[0] : word_q[1];
      bus_d[1] = swap_q ? word_q[1] : word_q[0];
      // drive only when the routed channel is in normal operation [R6] [R8]
      bus_oe_d[0] = swap_q ? (state_q[0] == CH_NORMAL)
                           : (state_q[1] == CH_NORMAL);
      bus_oe_d[1] = swap_q ? (state_q[1] == CH_NORMAL)
                           : (state_q[0] == CH_NORMAL);
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         bus_q[0] <= '0;
         bus_q[1] <= '0;
         bus_oe_q <= 2'b00;
      end else begin
         bus_q[0] <= bus_d[0];
         bus_q[1] <= bus_d[1];
         bus_oe_q <= bus_oe_d;
      end
   end

   assign result_bus_a = bus_q[0].code;
   assign range_flag_bus_a = bus_q[0].range;
   assign result_bus_a_oe = bus_oe_q[0];
   assign range_flag_bus_a_oe = bus_oe_q[0];
   assign result_bus_b = bus_q[1].code;
   assign range_flag_bus_b = bus_q[1].range;
   assign result_bus_b_oe = bus_oe_q[1];
   assign range_flag_bus_b_oe = bus_oe_q[1];
   assign duty_stab_on = stab_q;

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite slave: address and data taken in either order

   logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
   logic [`AXI_AW-1:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_d;
   logic [3:0] wstrb_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;

   always_comb begin
      aw_hold_d = aw_hold_q;
      w_hold_d = w_hold_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      wr_ctrl = 1'b0;
      if (s_axi_awvalid && awready_q) begin
         aw_hold_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
         w_hold_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (aw_hold_q && w_hold_q && !bvalid_q) begin
         aw_hold_d = 1'b0;
         w_hold_d = 1'b0;
         bvalid_d = 1'b1;
         wr_ctrl = (awaddr_q == `ADDR_CTRL);
         case (awaddr_q)
            `ADDR_CTRL, `ADDR_STAT, `ADDR_RES_A, `ADDR_RES_B:
               bresp_d = `RESP_OKAY;
            default: bresp_d = `RESP_SLVERR;
         endcase
      end
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rresp_d = `RESP_OKAY;
         case (s_axi_araddr)
            `ADDR_CTRL: rdata_d = {24'h00_0000, ctrl_q};
            `ADDR_STAT: rdata_d = {21'h00_0000, swap_q, twos_q, stab_q,
                                   state_q[1], state_q[0]};
            `ADDR_RES_A: rdata_d = {21'h00_0000, word_q[0]};
            `ADDR_RES_B: rdata_d = {21'h00_0000, word_q[1]};
            default: begin
               rdata_d = 32'h0000_0000;
               rresp_d = `RESP_SLVERR;
            end
         endcase
      end
      awready_d = !aw_hold_d;
      wready_d = !w_hold_d;
      arready_d = !rvalid_d;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= `RESP_OKAY;
         rdata_q <= 32'h0000_0000;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         arready_q <= 1'b0;
      end else begin
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         arready_q <= arready_d;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // assertions

   property p_sample_edge;
      @(posedge ref_clk) disable iff (sys_rst)
      (edge_s[0] && active[0]) |=> (pipe_q[0][0] == $past(raw[0]));
   endproperty
   a_sample_edge: assert property (p_sample_edge) // [R1]
      else $error("channel A did not sample on its edge");

   property p_swap_high;
      @(posedge ref_clk) disable iff (sys_rst)
      swap_q |=> (bus_q[0] == $past(word_q[0])) &&
                 (bus_q[1] == $past(word_q[1]));
   endproperty
   a_swap_high: assert property (p_swap_high) // [R2]
      else $error("straight routing wrong");

   property p_swap_low;
      @(posedge ref_clk) disable iff (sys_rst)
      !swap_q |=> (bus_q[0] == $past(word_q[1])) &&
                  (bus_q[1] == $past(word_q[0]));
   endproperty
   a_swap_low: assert property (p_swap_low) // [R3]
      else $error("crossed routing wrong");

   property p_normal;
      @(posedge ref_clk) disable iff (sys_rst)
      (!ctrl_q.pd_a && !ctrl_q.oen_a && swap_q && !ctrl_q.swap_follow &&
       ctrl_q == $past(ctrl_q))
      |=> (state_q[0] == CH_NORMAL) ##1 bus_oe_q[0];
   endproperty
   a_normal: assert property (p_normal) // [R6]
      else $error("normal channel not driving");

   property p_hiz_converts;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_q[0] == CH_HIZ && edge_s[0]) |=> (pipe_q[0][0] == $past(raw[0]));
   endproperty
   a_hiz_converts: assert property (p_hiz_converts) // [R7]
      else $error("high impedance channel stopped converting");

   property p_nap_quiet;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_q[0] == CH_NAP) |=> $stable(pipe_q[0][0]);
   endproperty
   a_nap_quiet: assert property (p_nap_quiet) // [R8]
      else $error("napping channel still converting");

   property p_off_hiz;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_q[0] != CH_NORMAL && swap_q) |=> !bus_oe_q[0];
   endproperty
   a_off_hiz: assert property (p_off_hiz) // [R7] [R8] [R9]
      else $error("disabled channel drives its bus");

   property p_mode_stab;
      @(posedge ref_clk) disable iff (sys_rst)
      1'b1 |=> (stab_q == ($past(ctrl_q.mode) == MODE_THIRD ||
                           $past(ctrl_q.mode) == MODE_TWO_THIRDS));
   endproperty
   a_mode_stab: assert property (p_mode_stab) // [R11] [R12]
      else $error("stabilizer setting wrong");

   property p_format;
      @(posedge ref_clk) disable iff (sys_rst)
      (edge_s[1] && active[1]) |=>
         (word_q[1].code[`RES_W-1] ==
          ($past(pipe_q[1][LAT-1].code[`RES_W-1]) ^ $past(twos_q))) &&
         (word_q[1].range == $past(pipe_q[1][LAT-1].range));
   endproperty
   a_format: assert property (p_format) // [R15] [R16]
      else $error("output word coding or flag alignment wrong");

endmodule
`default_nettype wire

// ==== verification/result_capture.sv ====
// downstream capture model of the two result buses
// assumes buses and enables are registered on ref_clk by the converter
`timescale 1ns/1ps
`default_nettype none
`include "dual_adc_consts.svh"

module result_capture
   import dual_adc_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // bus a pins
   input wire logic [`RES_W-1:0] word_a,
   input wire logic flag_a,
   input wire logic oe_a,
   // bus b pins
   input wire logic [`RES_W-1:0] word_b,
   input wire logic flag_b,
   input wire logic oe_b,
   // capture registers
   output var sample_t cap_a_q,
   output var sample_t cap_b_q
);
   sample_t cap_a_d;
   sample_t cap_b_d;

   ////////////////////////////////////////////////////////////////////////
   // a released bus floats: show the inverse of the last capture each cycle,
   // so a stale word returns on every second released cycle
   always_comb begin
      cap_a_d = oe_a ? {flag_a, word_a} : ~cap_a_q;
      cap_b_d = oe_b ? {flag_b, word_b} : ~cap_b_q;
   end

   always_ff @(posedge ref_clk) begin
      cap_a_q <= cap_a_d;
      cap_b_q <= cap_b_d;
   end
endmodule
`default_nettype wire

// ==== verification/dual_adc_output_control_bench.sv ====
// scenario bench of the dual converter output control, with AXI4-Lite master
// assumes the package, the design and result_capture are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "dual_adc_consts.svh"

module dual_adc_output_control_bench
   import dual_adc_pkg::*;
;
   localparam int LAT = `PIPE_LAT;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic sample_clock_chan_a = 1'b0;
   logic sample_clock_chan_b = 1'b0;
   sample_t raw_a = '0;
   sample_t raw_b = '0;
   logic [`RES_W-1:0] result_bus_a, result_bus_b;
   logic result_bus_a_oe, result_bus_b_oe, range_flag_bus_a, range_flag_bus_b;
   logic range_flag_bus_a_oe, range_flag_bus_b_oe, duty_stab_on;
   logic [3:0] awaddr = '0;
   logic [3:0] araddr = '0;
   logic [3:0] wstrb = 4'hf;
   logic [31:0] wdata = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   sample_t cap_a, cap_b;
   ctrl_t ctl = ctrl_t'(`CTRL_RST);
   sample_t ha[$];
   sample_t hb[$];
   int n_errors = 0;
   int n_checks = 0;

   always #20 ref_clk = ~ref_clk;

   dual_adc_output_control #(.LAT(LAT)) dual_adc_output_control_i (
      .ref_clk(ref_clk), .sys_rst(sys_rst),
      .sample_clock_chan_a(sample_clock_chan_a),
      .sample_clock_chan_b(sample_clock_chan_b),
      .raw_code_chan_a(raw_a.code), .raw_range_chan_a(raw_a.range),
      .raw_code_chan_b(raw_b.code), .raw_range_chan_b(raw_b.range),
      .result_bus_a(result_bus_a), .result_bus_a_oe(result_bus_a_oe),
      .range_flag_bus_a(range_flag_bus_a),
      .range_flag_bus_a_oe(range_flag_bus_a_oe),
      .result_bus_b(result_bus_b), .result_bus_b_oe(result_bus_b_oe),
      .range_flag_bus_b(range_flag_bus_b),
      .range_flag_bus_b_oe(range_flag_bus_b_oe),
      .duty_stab_on(duty_stab_on),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   result_capture result_capture_i (
      .ref_clk(ref_clk), .word_a(result_bus_a), .flag_a(range_flag_bus_a),
      .oe_a(result_bus_a_oe), .word_b(result_bus_b), .flag_b(range_flag_bus_b),
      .oe_b(result_bus_b_oe), .cap_a_q(cap_a), .cap_b_q(cap_b));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] got, exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
      output logic [1:0] r);
      int t;
      bit done;
      t = 0;
      done = 0;
      r = 2'b11;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done && t < 200) begin
         @(posedge ref_clk);
         t++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            done = 1;
            bready <= 1'b0;
         end
      end
      chk(done, 1, "write answer");
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
      output logic [1:0] r);
      int t;
      bit done;
      t = 0;
      done = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done && t < 200) begin
         @(posedge ref_clk);
         t++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            done = 1;
            rready <= 1'b0;
         end
      end
      chk(done, 1, "read answer");
   endtask

   task automatic wr_ctrl(input ctrl_t c);
      logic [1:0] r;
      axi_wr(`ADDR_CTRL, {24'h0, c}, r);
      chk(r, `RESP_OKAY, "ctrl write");
      ctl = c;
      repeat (3) @(posedge ref_clk);
   endtask

   // a channel in nap or sleep ignores its sample clock
   task automatic clk_up(input logic ea, eb, input sample_t va, vb);
      @(posedge ref_clk);
      raw_a <= va;
      raw_b <= vb;
      sample_clock_chan_a <= ea;
      sample_clock_chan_b <= eb;
      if (ea && !ctl.pd_a) ha.push_back(va);
      if (eb && !ctl.pd_b) hb.push_back(vb);
   endtask

   task automatic pulse(input logic ea, eb, input sample_t va, vb);
      clk_up(ea, eb, va, vb);
      repeat (3) @(posedge ref_clk);
      sample_clock_chan_a <= 1'b0;
      sample_clock_chan_b <= 1'b0;
      // edge filter, word, bus pin and capture each take one cycle
      repeat (4) @(posedge ref_clk);
   endtask

   function automatic sample_t want(input bit ch_b);
      sample_t s;
      s = ch_b ? hb[$-LAT] : ha[$-LAT];
      if (ctl.mode[1]) s.code[`RES_W-1] = ~s.code[`RES_W-1];
      return s;
   endfunction

   task automatic check_buses(input bit sw);
      logic oa, ob;
      oa = sw ? (!ctl.pd_a && !ctl.oen_a) : (!ctl.pd_b && !ctl.oen_b);
      ob = sw ? (!ctl.pd_b && !ctl.oen_b) : (!ctl.pd_a && !ctl.oen_a);
      chk(result_bus_a_oe, oa, "oe a");
      chk(range_flag_bus_a_oe, oa, "flag oe a");
      chk(result_bus_b_oe, ob, "oe b");
      chk(range_flag_bus_b_oe, ob, "flag oe b");
      if (oa) chk(cap_a, want(!sw), "bus a");
      if (ob) chk(cap_b, want(sw), "bus b");
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [1:0] r;
      logic [31:0] d;
      axi_rd(`ADDR_CTRL, d, r);
      chk({d, r}, {32'h0000_0001, `RESP_OKAY}, "ctrl reset");
      axi_rd(`ADDR_STAT, d, r);
      chk(d, 32'h0000_0411, "stat reset");
      chk(duty_stab_on, 0, "stab reset");
      check_buses(1);
   endtask

   task automatic t_latency();
      logic [1:0] r;
      logic [31:0] d;
      for (int i = 0; i < 8; i++) begin
         pulse(1, 1, sample_t'(11'(i * 150 + 9)),
               sample_t'(11'(2047 - i * 131)));
         check_buses(1);
      end
      pulse(1, 0, sample_t'(11'h155), '0);
      check_buses(1);
      axi_rd(`ADDR_RES_A, d, r);
      chk(d, {21'h0, want(0)}, "result reg a");
   endtask

   task automatic t_swap();
      ctrl_t c;
      c = ctl;
      c.swap_sel = 1'b0;
      wr_ctrl(c);
      pulse(1, 1, sample_t'(11'h2aa), sample_t'(11'h455));
      check_buses(0);
      c.swap_sel = 1'b1;
      wr_ctrl(c);
      check_buses(1);
   endtask

   task automatic t_modes();
      ctrl_t c;
      c = ctl;
      for (int m = 0; m < 4; m++) begin
         c.mode = mode_level_t'(m);
         wr_ctrl(c);
         chk(duty_stab_on, m == 1 || m == 2, "stabilizer");
         for (int i = 0; i <= LAT; i++) begin
            pulse(1, 1, sample_t'(11'(m * 300 + i * 61)),
                  sample_t'(11'(i * 77)));
         end
         check_buses(1);
      end
   endtask

   task automatic t_power();
      ctrl_t c;
      logic [1:0] r;
      logic [31:0] d;
      c = ctl;
      for (int k = 0; k < 4; k++) begin
         c.pd_a = k[1];
         c.oen_a = k[0];
         c.pd_b = !k[1];
         c.oen_b = !k[0];
         wr_ctrl(c);
         axi_rd(`ADDR_STAT, d, r);
         chk(d[7:0], {4'h8 >> k, 4'h1 << k}, "states");
         pulse(1, 1, sample_t'(11'(k * 97 + 5)),
               sample_t'(11'(k * 51 + 700)));
         check_buses(1);
      end
      c = ctl;
      {c.pd_a, c.oen_a, c.pd_b, c.oen_b} = 4'h0;
      wr_ctrl(c);
      for (int i = 0; i < LAT; i++) begin
         pulse(1, 1, sample_t'(11'(i * 33 + 400)), sample_t'(11'(i * 19)));
         check_buses(1);
      end
   endtask

   task automatic t_axi();
      logic [1:0] r;
      logic [31:0] d;
      axi_rd(4'h2, d, r);
      chk({d, r}, {32'h0000_0000, `RESP_SLVERR}, "unmapped read");
      axi_wr(4'h2, 32'h0000_00ff, r);
      chk(r, `RESP_SLVERR, "unmapped write");
      axi_wr(`ADDR_STAT, 32'hffff_ffff, r);
      chk(r, `RESP_OKAY, "stat write");
      axi_rd(`ADDR_CTRL, d, r);
      chk(d, {24'h0, ctl}, "ctrl kept");
   endtask

   task automatic t_interleave();
      ctrl_t c;
      c = ctl;
      c.swap_follow = 1'b1;
      wr_ctrl(c);
      for (int i = 0; i <= LAT; i++) begin
         // one shared clock of 17 ref_clk cycles, about 1.5 MHz, well under 80 Msps
         clk_up(1, 1, sample_t'(11'(i * 91 + 1)),
                sample_t'(11'(i * 45 + 600)));
         repeat (8) @(posedge ref_clk);
         check_buses(1);
         sample_clock_chan_a <= 1'b0;
         sample_clock_chan_b <= 1'b0;
         repeat (8) @(posedge ref_clk);
         check_buses(0);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      report_and_stop();
   end

   initial begin
      // one spare zero so the first look-up never indexes below the queue
      repeat (LAT + 1) begin
         ha.push_back('0);
         hb.push_back('0);
      end
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      t_reset();
      t_latency();
      t_swap();
      t_modes();
      t_power();
      t_axi();
      t_interleave();
      report_and_stop();
   end
endmodule
`default_nettype wire
